// file: design/tcc_edge_det.sv
// two-sample noise filter and edge detector for the capture pins
`timescale 1ns/1ps
module tcc_edge_det #(
    parameter int PINS = 2
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // to core
    tcc_tick_if.edges tk
);
    import tcc_pkg::*;

    typedef struct packed {
        logic [PINS-1:0] samp;
        logic [PINS-1:0] filt;
        logic [PINS-1:0] rise;
        logic [PINS-1:0] fall;
        logic            started;
    } tcc_edge_state_t;

    tcc_edge_state_t r;
    tcc_edge_state_t n;

    always_comb begin
        n      = r;
        n.rise = '0;
        n.fall = '0;
        if (!tk.run) begin
            // after the first run, a restart must not see a held-high pin as rising
            if (r.started) begin
                n.samp = tk.pin_lvl[PINS-1:0];
                n.filt = tk.pin_lvl[PINS-1:0];
            end
        end else begin
            n.started = 1'b1;
            if (tk.cnt_tick) begin
                for (int i = 0; i < PINS; i++) begin
                    n.samp[i] = tk.pin_lvl[i];
                    // level must be seen on two count clocks in a row
                    if (r.samp[i] == tk.pin_lvl[i] && tk.pin_lvl[i] != r.filt[i]) begin
                        n.filt[i] = tk.pin_lvl[i];
                        n.rise[i] = tk.pin_lvl[i];
                        n.fall[i] = !tk.pin_lvl[i];
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign tk.rise = r.rise;
    assign tk.fall = r.fall;
endmodule : tcc_edge_det

// file: design/tcc_pkg.sv
// constants, field positions and types shared by the capture/compare timer files
package tcc_pkg;

    localparam int CNT_W  = 16;
    localparam int ADDR_W = 3;
    localparam int DIV_W  = 6;

    // register indexes on the plain register port
    localparam logic [ADDR_W-1:0] ADDR_COUNT     = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_FIRST_CC  = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_SECOND_CC = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_MODE_CTL  = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_CC_CTL    = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_OUT_CTL   = 3'h5;
    localparam logic [ADDR_W-1:0] ADDR_PRESCALE  = 3'h6;

    // timer_mode_control fields
    localparam int MODE_OVF_BIT = 0;
    localparam int MODE_LO_BIT  = 2;

    // capture_compare_control fields
    localparam int CC_FIRST_CAPT_BIT  = 0;
    localparam int CC_FIRST_SRC_BIT   = 1;
    localparam int CC_SECOND_CAPT_BIT = 2;
    localparam int CC_W               = 3;

    // timer_output_control fields
    localparam int OUT_EN_BIT        = 0;
    localparam int OUT_T1_BIT        = 1;
    localparam int OUT_PRESET_LO_BIT = 2;
    localparam int OUT_PRESET_HI_BIT = 3;
    localparam int OUT_T2_BIT        = 4;
    localparam int OUT_W             = 5;

    // prescaler_select fields
    localparam int PRE_SEL_LO_BIT    = 0;
    localparam int PRE_FIRST_EDGE_LO = 4;
    localparam int PRE_SECOND_EDGE_LO = 6;
    localparam int PRE_W             = 8;

    // reset values and count maximum
    localparam logic [CNT_W-1:0] RST_WORD  = 16'h0000;
    localparam logic [CNT_W-1:0] COUNT_MAX = 16'hFFFF;
    localparam logic [PRE_W-1:0] RST_PRE   = 8'h00;

    // divide masks: ratios 1, 4, 16, 64
    localparam logic [DIV_W-1:0] DIV_MASK_0 = 6'h00;
    localparam logic [DIV_W-1:0] DIV_MASK_1 = 6'h03;
    localparam logic [DIV_W-1:0] DIV_MASK_2 = 6'h0F;
    localparam logic [DIV_W-1:0] DIV_MASK_3 = 6'h3F;

    typedef enum logic [1:0] {
        TCC_MODE_STOP      = 2'b00,
        TCC_MODE_FREE      = 2'b01,
        TCC_MODE_EDGE_CLR  = 2'b10,
        TCC_MODE_MATCH_CLR = 2'b11
    } tcc_mode_t;

    typedef enum logic [1:0] {
        TCC_EDGE_FALL = 2'b00,
        TCC_EDGE_RISE = 2'b01,
        TCC_EDGE_NONE = 2'b10,
        TCC_EDGE_BOTH = 2'b11
    } tcc_edge_t;

endpackage : tcc_pkg

// file: design/tcc_prescaler.sv
// free-running divider giving the one-cycle count clock enable
`timescale 1ns/1ps
module tcc_prescaler (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // to core
    tcc_tick_if.prescaler tk
);
    import tcc_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic             tick;
    } tcc_pre_state_t;

    tcc_pre_state_t r;
    tcc_pre_state_t n;

    function automatic logic [DIV_W-1:0] sel_mask(input logic [1:0] sel);
        case (sel)
            2'b00:   sel_mask = DIV_MASK_0;
            2'b01:   sel_mask = DIV_MASK_1;
            2'b10:   sel_mask = DIV_MASK_2;
            default: sel_mask = DIV_MASK_3;
        endcase
    endfunction : sel_mask

    // never restarted by the timer start, so the first tick lands anywhere
    // within one count period after start
    always_comb begin
        n      = r;
        n.div  = r.div + 6'h01;
        n.tick = ((r.div & sel_mask(tk.prescale_sel)) == sel_mask(tk.prescale_sel));
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign tk.cnt_tick = r.tick;
endmodule : tcc_prescaler

// file: design/tcc_tick_if.sv
// carrier between the timer core, its prescaler and its pin edge detector
`timescale 1ns/1ps
interface tcc_tick_if;
    logic [1:0] prescale_sel;
    logic       cnt_tick;
    logic       run;
    logic [1:0] pin_lvl;
    logic [1:0] rise;
    logic [1:0] fall;

    modport prescaler (input prescale_sel, output cnt_tick);
    modport edges     (input cnt_tick, input run, input pin_lvl, output rise, output fall);
endinterface : tcc_tick_if

// file: design/tcc_timer.sv
// 16-bit capture/compare timer core with register port and timer output
// What this block does
// - mode 01 free runs, 00 stops
// - edge-clear mode: capture into second, clear count
// - first register captures on selected source edge
// - second register captures on first pin trigger
// - reverse-phase capture raises no first interrupt
// - preset pair: hold, low, high, forbidden
// - clearing preset keeps the forced level
// - output starts from preset, toggles on match
// - first match may slip one count clock
// - capture during read still happens
// - match clear at maximum sets overflow flag
`timescale 1ns/1ps
module tcc_timer (
    // clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          reset_n,
    // register port
    input  wire logic [tcc_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [tcc_pkg::CNT_W-1:0]     reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [tcc_pkg::CNT_W-1:0]     reg_rdata,
    // capture pins
    input  wire logic                          first_capture_pin,
    input  wire logic                          second_capture_pin,
    // timer output and events
    output logic                               timer_output_pin,
    output logic                               first_match_irq,
    output logic                               second_match_irq
);
    import tcc_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] first_cc;
        logic [CNT_W-1:0] second_cc;
        tcc_mode_t        mode;
        logic             ovf;
        logic [CC_W-1:0]  cc_ctl;
        logic [OUT_W-1:0] out_ctl;
        logic [PRE_W-1:0] prescale;
        logic             out_level;
        logic             pin_out;
        logic             irq1;
        logic             irq2;
        logic [CNT_W-1:0] rdata;
    } tcc_core_state_t;

    tcc_core_state_t r;
    tcc_core_state_t n;

    tcc_tick_if tk ();

    assign tk.prescale_sel = r.prescale[PRE_SEL_LO_BIT +: 2];
    assign tk.run          = (r.mode != TCC_MODE_STOP);
    assign tk.pin_lvl      = {second_capture_pin, first_capture_pin};

    tcc_prescaler u_prescaler (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .tk      (tk)
    );

    tcc_edge_det #(.PINS(2)) u_edge_det (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .tk      (tk)
    );

    // decides whether a detected edge matches an edge selection
    function automatic logic edge_ok(input logic [1:0] sel, input logic rise,
                                     input logic fall);
        case (sel)
            TCC_EDGE_FALL: edge_ok = fall;
            TCC_EDGE_RISE: edge_ok = rise;
            TCC_EDGE_BOTH: edge_ok = rise | fall;
            default:       edge_ok = 1'b0;
        endcase
    endfunction : edge_ok

    logic [1:0] first_sel;
    logic [1:0] second_sel;
    logic       first_valid;
    logic       first_rev;
    logic       second_valid;
    logic       running;
    logic       first_capt;
    logic       second_capt;
    logic       match1;
    logic       match2;

    always_comb begin
        first_sel    = r.prescale[PRE_FIRST_EDGE_LO +: 2];
        second_sel   = r.prescale[PRE_SECOND_EDGE_LO +: 2];
        first_valid  = edge_ok(first_sel, tk.rise[0], tk.fall[0]);
        // reverse phase: the opposite edge of the first pin's valid edge
        first_rev    = edge_ok(first_sel, tk.fall[0], tk.rise[0]);
        second_valid = edge_ok(second_sel, tk.rise[1], tk.fall[1]);
        running      = (r.mode != TCC_MODE_STOP);
        first_capt   = r.cc_ctl[CC_FIRST_CAPT_BIT];
        second_capt  = r.cc_ctl[CC_SECOND_CAPT_BIT];
        match1       = tk.cnt_tick && !first_capt && (r.count == r.first_cc);
        match2       = tk.cnt_tick && !second_capt && (r.count == r.second_cc);

        n       = r;
        n.irq1  = 1'b0;
        n.irq2  = 1'b0;
        n.rdata = RST_WORD;

        // software writes first; hardware updates below override them
        if (reg_wr) begin
            case (reg_addr)
                ADDR_FIRST_CC:  n.first_cc  = reg_wdata;
                ADDR_SECOND_CC: n.second_cc = reg_wdata;
                ADDR_MODE_CTL: begin
                    n.mode = tcc_mode_t'(reg_wdata[MODE_LO_BIT +: 2]);
                    // flag is cleared by writing zero; writing one keeps it
                    if (!reg_wdata[MODE_OVF_BIT]) begin
                        n.ovf = 1'b0;
                    end
                end
                ADDR_CC_CTL:    n.cc_ctl   = reg_wdata[CC_W-1:0];
                ADDR_OUT_CTL:   n.out_ctl  = reg_wdata[OUT_W-1:0];
                ADDR_PRESCALE:  n.prescale = reg_wdata[PRE_W-1:0];
                default: begin
                end
            endcase
        end

        // reads sample the live registers; a capture in the same cycle
        // still lands, the read value is simply the older one
        if (reg_rd) begin
            case (reg_addr)
                ADDR_COUNT:     n.rdata = r.count;
                ADDR_FIRST_CC:  n.rdata = r.first_cc;
                ADDR_SECOND_CC: n.rdata = r.second_cc;
                ADDR_MODE_CTL:  n.rdata = {12'h000, r.mode, 1'b0, r.ovf};
                ADDR_CC_CTL:    n.rdata = {13'h0000, r.cc_ctl};
                ADDR_OUT_CTL:   n.rdata = {11'h000, r.out_ctl};
                ADDR_PRESCALE:  n.rdata = {8'h00, r.prescale};
                default:        n.rdata = RST_WORD;
            endcase
        end

        if (!running) begin
            // stopped: counter held at zero, preset pair drives the level
            n.count = RST_WORD;
            case ({r.out_ctl[OUT_PRESET_HI_BIT], r.out_ctl[OUT_PRESET_LO_BIT]})
                2'b10:   n.out_level = 1'b1;
                2'b01:   n.out_level = 1'b0;
                // 00 keeps the forced level, 11 is ignored
                default: n.out_level = r.out_level;
            endcase
        end else begin
            // compares act only on count clock enables
            if (match1) begin
                n.irq1 = 1'b1;
                // level started from the preset, inverts per first match
                if (r.out_ctl[OUT_T1_BIT]) begin
                    n.out_level = !n.out_level;
                end
            end
            if (match2) begin
                n.irq2 = 1'b1;
                if (r.out_ctl[OUT_T2_BIT]) begin
                    n.out_level = !n.out_level;
                end
            end

            if (tk.cnt_tick) begin
                if (r.mode == TCC_MODE_MATCH_CLR && match1) begin
                    n.count = RST_WORD;
                    if (r.count == COUNT_MAX) begin
                        n.ovf = 1'b1;
                    end
                end else begin
                    n.count = r.count + 16'h0001;
                    if (r.count == COUNT_MAX) begin
                        n.ovf = 1'b1;
                    end
                end
            end

            // first capture register source: second pin or reverse phase
            if (first_capt) begin
                if (r.cc_ctl[CC_FIRST_SRC_BIT]) begin
                    if (first_rev) begin
                        n.first_cc = r.count;
                        // no first interrupt on the reverse-phase capture
                    end
                    // second pin edge only signals, nothing is captured
                    if (second_valid) begin
                        n.irq1 = 1'b1;
                    end
                end else if (second_valid) begin
                    n.first_cc = r.count;
                    n.irq1     = 1'b1;
                end
            end

            if (first_valid && (second_capt || r.mode == TCC_MODE_EDGE_CLR)) begin
                n.second_cc = r.count;
                n.irq2      = 1'b1;
            end
            // clear after copying the count; the clear overrides any
            // increment from a tick in the same cycle
            if (first_valid && r.mode == TCC_MODE_EDGE_CLR) begin
                n.count = RST_WORD;
            end
        end

        n.pin_out = n.out_level & n.out_ctl[OUT_EN_BIT];
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign reg_rdata        = r.rdata;
    assign timer_output_pin = r.pin_out;
    assign first_match_irq  = r.irq1;
    assign second_match_irq = r.irq2;
endmodule : tcc_timer

// file: tb/tb_top.sv
// self-checking bench for the capture/compare timer
`timescale 1ns/1ps
module tb_top;
    import tcc_pkg::*;
    logic              sys_clk;
    logic              reset_n;
    logic [ADDR_W-1:0] reg_addr;
    logic [CNT_W-1:0]  reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [CNT_W-1:0]  reg_rdata;
    logic              first_capture_pin;
    logic              second_capture_pin;
    logic              timer_output_pin;
    logic              first_match_irq;
    logic              second_match_irq;
    logic [CNT_W-1:0]  d1;
    logic [CNT_W-1:0]  d2;
    logic [CNT_W-1:0]  pv [5] = '{16'h0009, 16'h0001, 16'h0005, 16'h0001, 16'h0009};
    logic              pe [5] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1};
    int                err_count = 0;
    int                cmp_count = 0;
    int                cyc = 0;
    int                fm_cnt = 0;
    int                n;
    int                i;

    tcc_timer u_tcc_timer (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .first_capture_pin(first_capture_pin), .second_capture_pin(second_capture_pin),
        .timer_output_pin(timer_output_pin), .first_match_irq(first_match_irq),
        .second_match_irq(second_match_irq));
    tcc_pulse_src u_tcc_pulse_src (.sys_clk(sys_clk), .first_capture_pin(first_capture_pin),
        .second_capture_pin(second_capture_pin));

    initial begin
        sys_clk = 1'h0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic end_of_test();
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // the overflow case alone needs some 65,600 cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (first_match_irq === 1'h1) begin
            fm_cnt++;
        end
        if (cyc == 80000) begin
            err_count++;
            $display("FAIL %0t run did not finish", $time);
            end_of_test();
        end
    end

    task automatic chk(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] v);
        @(posedge sys_clk);
        reg_wr    <= 1'h1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr    <= 1'h0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [CNT_W-1:0] v);
        @(posedge sys_clk);
        reg_rd   <= 1'h1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'h0;
        @(negedge sys_clk);
        v = reg_rdata;
    endtask : rd

    // two count reads on consecutive edges
    task automatic rd_pair(output logic [CNT_W-1:0] a, output logic [CNT_W-1:0] b);
        @(posedge sys_clk);
        reg_rd   <= 1'h1;
        reg_addr <= ADDR_COUNT;
        @(posedge sys_clk);
        @(negedge sys_clk);
        a = reg_rdata;
        @(posedge sys_clk);
        reg_rd   <= 1'h0;
        @(negedge sys_clk);
        b = reg_rdata;
    endtask : rd_pair

    task automatic wait_ev(input logic sec, input int lim, output int cnt);
        cnt = 0;
        do begin
            @(negedge sys_clk);
            cnt++;
        end while ((sec ? second_match_irq : first_match_irq) !== 1'h1 && cnt < lim);
        if (cnt >= lim) begin
            err_count++;
            $display("FAIL %0t awaited event missing", $time);
        end
    endtask : wait_ev

    initial begin
        reset_n   = 1'h0;
        reg_wr    = 1'h0;
        reg_rd    = 1'h0;
        reg_addr  = '0;
        reg_wdata = '0;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'h1;
        // read-only count and unmapped index ignore writes
        wr(ADDR_COUNT, 16'h1234);
        wr(3'h7, 16'hFFFF);
        for (i = 0; i < 8; i++) begin
            rd(3'(i), d1);
            chk(d1, RST_WORD);
        end
        wr(ADDR_MODE_CTL, 16'h0004);
        repeat (5) @(posedge sys_clk);
        rd_pair(d1, d2);
        chk(d2 - d1, 16'h0001);
        wr(ADDR_MODE_CTL, 16'h0000);
        wr(ADDR_PRESCALE, 16'h0001);
        wr(ADDR_MODE_CTL, 16'h0004);
        rd(ADDR_COUNT, d1);
        repeat (62) @(posedge sys_clk);
        rd(ADDR_COUNT, d2);
        chk(d2 - d1, 16'h0010);
        wr(ADDR_MODE_CTL, 16'h0000);
        rd(ADDR_COUNT, d1);
        chk(d1, RST_WORD);
        for (i = 0; i < 5; i++) begin
            wr(ADDR_OUT_CTL, pv[i]);
            repeat (4) @(negedge sys_clk);
            chk({15'h0000, timer_output_pin}, {15'h0000, pe[i]});
        end
        // divide by one, so match periods and toggles land on known cycles
        wr(ADDR_PRESCALE, 16'h0000);
        wr(ADDR_FIRST_CC, 16'h0014);
        wr(ADDR_SECOND_CC, 16'h000A);
        wr(ADDR_OUT_CTL, 16'h0003);
        wr(ADDR_MODE_CTL, 16'h000C);
        @(negedge sys_clk);
        chk({15'h0000, timer_output_pin}, 16'h0001);
        wait_ev(1'h0, 40, n);
        repeat (3) @(negedge sys_clk);
        chk({15'h0000, timer_output_pin}, 16'h0000);
        wait_ev(1'h1, 40, n);
        repeat (3) @(negedge sys_clk);
        chk({15'h0000, timer_output_pin}, 16'h0000);
        wr(ADDR_SECOND_CC, 16'h0005);
        wr(ADDR_OUT_CTL, 16'h0013);
        wait_ev(1'h0, 40, n);
        wait_ev(1'h1, 40, n);
        repeat (3) @(negedge sys_clk);
        chk({15'h0000, timer_output_pin}, 16'h0000);
        wait_ev(1'h0, 40, n);
        wait_ev(1'h0, 40, n);
        chk(16'(n), 16'h0015);
        wr(ADDR_MODE_CTL, 16'h0000);
        wr(ADDR_OUT_CTL, 16'h0000);
        wr(ADDR_CC_CTL, 16'h0007);
        wr(ADDR_PRESCALE, 16'h0090);
        wr(ADDR_MODE_CTL, 16'h0004);
        i = fm_cnt;
        fork
            u_tcc_pulse_src.pulse(0, 40);
            wait_ev(1'h1, 30, n);
        join
        repeat (10) @(negedge sys_clk);
        rd(ADDR_FIRST_CC, d1);
        rd(ADDR_SECOND_CC, d2);
        chk(d1 - d2, 16'h0028);
        chk(16'(fm_cnt - i), 16'h0000);
        wr(ADDR_MODE_CTL, 16'h0000);
        wr(ADDR_MODE_CTL, 16'h0008);
        u_tcc_pulse_src.pulse(0, 10);
        repeat (39) @(posedge sys_clk);
        fork
            u_tcc_pulse_src.pulse(0, 10);
            wait_ev(1'h1, 30, n);
        join
        rd(ADDR_SECOND_CC, d1);
        rd(ADDR_COUNT, d2);
        chk({15'h0000, d1 == 16'h0031 || d1 == 16'h0032}, 16'h0001);
        chk({15'h0000, d2 < 16'h0010}, 16'h0001);
        wr(ADDR_MODE_CTL, 16'h0000);
        wr(ADDR_CC_CTL, 16'h0000);
        wr(ADDR_FIRST_CC, 16'hFFFF);
        wr(ADDR_MODE_CTL, 16'h000C);
        wait_ev(1'h0, 66000, n);
        rd(ADDR_MODE_CTL, d1);
        chk(d1, 16'h000D);
        wr(ADDR_MODE_CTL, 16'h000C);
        rd(ADDR_MODE_CTL, d1);
        chk(d1, 16'h000C);
        wr(ADDR_MODE_CTL, 16'h0000);
        end_of_test();
    end
endmodule : tb_top

// file: tb/tcc_pulse_src.sv
// external pulse source on the two capture pins
`timescale 1ns/1ps
module tcc_pulse_src (
    // clock
    input wire logic sys_clk,
    // capture pins
    output logic     first_capture_pin,
    output logic     second_capture_pin
);
    logic [1:0] lvl = 2'h0;
    assign first_capture_pin  = lvl[0];
    assign second_capture_pin = lvl[1];
    // width must exceed two count clocks or the noise filter drops it;
    // blocking, so no new trigger starts before the pulse ends
    task automatic pulse(input int which, input int width);
        @(posedge sys_clk);
        lvl[which] <= 1'h1;
        repeat (width) @(posedge sys_clk);
        lvl[which] <= 1'h0;
    endtask : pulse
endmodule : tcc_pulse_src

// file: tb/tcc_timer_sva.sv
// concurrent checks on the capture/compare timer ports
`timescale 1ns/1ps
module tcc_timer_sva (
    // clock and reset
    input wire logic                       sys_clk,
    input wire logic                       reset_n,
    // register port
    input wire logic [tcc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [tcc_pkg::CNT_W-1:0]  reg_wdata,
    input wire logic                       reg_wr,
    input wire logic                       reg_rd,
    input wire logic [tcc_pkg::CNT_W-1:0]  reg_rdata,
    // pins and events
    input wire logic                       first_capture_pin,
    input wire logic                       second_capture_pin,
    input wire logic                       timer_output_pin,
    input wire logic                       first_match_irq,
    input wire logic                       second_match_irq
);
    import tcc_pkg::*;
    // write shadow, since the core's registers are out of reach
    logic [CNT_W-1:0] sh [8];
    logic [1:0]       mode_q;
    logic [CNT_W-1:0] gap;
    logic             seen;
    logic             stopped;
    logic             run1;
    logic             pwm;
    logic             rd_cnt;
    logic             out_wr;
    assign stopped = sh[ADDR_MODE_CTL][3:2] == 2'h0 && mode_q == 2'h0;
    assign run1    = sh[ADDR_MODE_CTL][3:2] == 2'h1 && mode_q == 2'h1 && sh[ADDR_PRESCALE][1:0] == 2'h0;
    assign pwm     = sh[ADDR_MODE_CTL][3:2] == 2'h3 && !sh[ADDR_CC_CTL][0]
                     && sh[ADDR_OUT_CTL][0] && sh[ADDR_PRESCALE][1:0] == 2'h0;
    assign rd_cnt  = reg_rd && reg_addr == ADDR_COUNT;
    assign out_wr  = reg_wr && reg_addr == ADDR_OUT_CTL && stopped;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sh     <= '{default: '0};
            mode_q <= 2'h0;
            gap    <= '0;
            seen   <= 1'h0;
        end else begin
            if (reg_wr) begin
                sh[reg_addr] <= reg_wdata;
            end
            mode_q <= sh[ADDR_MODE_CTL][3:2];
            gap    <= first_match_irq ? '0 : gap + 16'h0001;
            // any write may change the period, so restart the measurement
            seen   <= !reg_wr && (seen || first_match_irq);
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_stop_count_zero: assert property (rd_cnt && stopped |=> reg_rdata == RST_WORD)
        else $error("count not zero while stopped");
    a_free_count_step: assert property (rd_cnt && run1 ##1 rd_cnt && run1 |=>
        reg_rdata == $past(reg_rdata) + 16'h0001) else $error("free count step wrong");
    a_match_period: assert property (pwm && seen && first_match_irq |-> gap == sh[1])
        else $error("first match period wrong");
    a_first_toggle: assert property (pwm && sh[5][1] && first_match_irq |->
        ##2 timer_output_pin != $past(timer_output_pin, 3)) else $error("no toggle on first match");
    a_second_hold: assert property (pwm && !sh[5][4] && second_match_irq |->
        ##2 timer_output_pin == $past(timer_output_pin, 3)) else $error("disabled toggle moved");
    a_second_toggle: assert property (pwm && sh[5][4] && second_match_irq |->
        ##2 timer_output_pin != $past(timer_output_pin, 3)) else $error("no second toggle");
    a_preset_high: assert property (out_wr && reg_wdata[3:0] == 4'h9 |-> ##3 timer_output_pin)
        else $error("preset high not applied");
    a_preset_low: assert property (out_wr && reg_wdata[3:0] == 4'h5 |-> ##3 !timer_output_pin)
        else $error("preset low not applied");
    a_preset_keep: assert property (out_wr && reg_wdata[3:0] == 4'h1 && sh[5][0] |=>
        $stable(timer_output_pin)[*3]) else $error("cleared preset moved output");
    a_reverse_no_irq: assert property (sh[4][2:0] == 3'h7 && sh[6][7:6] == 2'h2
        |-> !first_match_irq) else $error("reverse phase capture raised irq");
endmodule : tcc_timer_sva

bind tcc_timer tcc_timer_sva u_tcc_timer_sva (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .first_capture_pin(first_capture_pin), .second_capture_pin(second_capture_pin),
    .timer_output_pin(timer_output_pin), .first_match_irq(first_match_irq),
    .second_match_irq(second_match_irq));
